// *** rtl/ubt_pkg.sv ***
// Shared constants, types and bit-length lookup for the serial bit-timing block
package ubt_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_DIV = 5'h04;
  localparam logic [4:0] OFS_TXD = 5'h08;
  localparam logic [4:0] OFS_RXD = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_PAR = 2;
  localparam int CTRL_STOP2 = 3;
  localparam int CTRL_SRC_LO = 4;
  localparam int CTRL_FA_LO = 8;
  localparam int STAT_RX_RDY = 0;
  localparam int STAT_FERR = 1;
  localparam int STAT_PERR = 2;
  localparam int STAT_TX_BUSY = 3;
  localparam int STAT_RX_BUSY = 4;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Bit timing
  // ------------------------------------------------------------
  localparam logic [2:0] FA_16 = 3'h0;
  localparam logic [2:0] FA_16_17 = 3'h1;
  localparam logic [2:0] FA_15 = 3'h2;
  localparam logic [2:0] FA_15_16 = 3'h3;
  localparam logic [2:0] FA_17 = 3'h4;
  localparam logic [4:0] RT_TOP_15 = 5'h0e;
  localparam logic [4:0] RT_TOP_16 = 5'h0f;
  localparam logic [4:0] RT_TOP_17 = 5'h10;
  localparam logic [4:0] RT_SAMPLE_HI = 5'h08;
  localparam logic [4:0] RT_SAMPLE_LO = 5'h06;
  localparam logic [4:0] RT_END = 5'h00;
  localparam logic [3:0] POS_START = 4'h0;
  localparam logic [3:0] POS_DATA_LAST = 4'h8;
  localparam logic [3:0] POS_PARITY = 4'h9;

  typedef struct packed {
    logic [2:0] fine_adjust;
    logic [1:0] source_sel;
    logic stop_two;
    logic parity_en;
    logic rx_en;
    logic tx_en;
  } ubt_cfg_type;

  // Starting sub-bit index of a bit; odd frame positions take the longer count
  function automatic logic [4:0] ubt_bit_top(input logic [2:0] code, input logic odd);
    case (code)
      FA_16_17: ubt_bit_top = odd ? RT_TOP_17 : RT_TOP_16;
      FA_15: ubt_bit_top = RT_TOP_15;
      FA_15_16: ubt_bit_top = odd ? RT_TOP_16 : RT_TOP_15;
      FA_17: ubt_bit_top = RT_TOP_17;
      default: ubt_bit_top = RT_TOP_16;
    endcase
  endfunction

endpackage

// *** rtl/ubt_rate_gen.sv ***
// Source prescaler and divisor counter producing the sub-bit clock enable
`timescale 1ns/1ps
module ubt_rate_gen #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Configuration
  input wire logic [1:0] source_sel,
  input wire logic [DIV_W-1:0] rate_divisor,
  // Enable out
  output logic sub_bit_tick
);
  import ubt_pkg::*;

  logic [2:0] pre_reg;
  logic [DIV_W-1:0] cnt_reg;
  logic [2:0] src_mask;
  logic src_tick;
  logic wrap;

  // Source 0 is the core clock, 1..3 divide it by 2, 4 and 8
  assign src_mask = (source_sel == 2'h0) ? 3'h0 :
                    (source_sel == 2'h1) ? 3'h1 :
                    (source_sel == 2'h2) ? 3'h3 : 3'h7;
  assign src_tick = ((pre_reg & src_mask) == src_mask);
  assign wrap = src_tick && (cnt_reg >= rate_divisor);

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pre_reg <= 3'h0;
      cnt_reg <= '0;
      sub_bit_tick <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_reg + 3'h1;
      sub_bit_tick <= wrap;
      if (wrap)
        cnt_reg <= '0;
      else if (src_tick)
        cnt_reg <= cnt_reg + DIV_W'(1);
    end
  end
endmodule

// *** rtl/ubt_top.sv ***
// Serial port bit timing, transmitter and majority-vote receiver behind AXI4-Lite
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ubt_top #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // AXI4-Lite write address and data
  input wire logic [ubt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ubt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link
  input wire logic serial_receive_input,
  output logic serial_transmit_output,
  // Event out
  output logic frame_error_req
);
  import ubt_pkg::*;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  ubt_cfg_type cfg_reg;
  logic [DIV_W-1:0] rate_divisor;
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [7:0] rx_data_reg;
  logic rx_ready_reg;
  logic ferr_reg;
  logic perr_reg;
  logic tx_busy_reg;
  logic rx_busy_reg;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_do;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic wr_hit_ctrl;
  logic wr_hit_div;
  logic wr_hit_txd;
  logic wr_mapped;
  logic rd_mapped;
  logic [31:0] wr_mask;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_new;
  logic [31:0] div_new;
  logic [31:0] stat_word;
  logic [31:0] rd_word;
  logic rx_clear;
  logic tx_start;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_do = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_addr = {aw_addr_reg[ADDR_W-1:2], 2'h0};
  assign rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'h0};
  assign wr_hit_ctrl = (wr_addr == OFS_CTRL);
  assign wr_hit_div = (wr_addr == OFS_DIV);
  assign wr_hit_txd = (wr_addr == OFS_TXD);
  assign wr_mapped = wr_hit_ctrl || wr_hit_div || wr_hit_txd;
  assign rd_mapped = (rd_addr <= OFS_STAT);
  assign wr_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
                    {8{w_strb_reg[0]}}};
  assign ctrl_word = {21'h0, cfg_reg.fine_adjust, 2'h0, cfg_reg.source_sel,
                      cfg_reg.stop_two, cfg_reg.parity_en, cfg_reg.rx_en, cfg_reg.tx_en};
  assign ctrl_new = (ctrl_word & ~wr_mask) | (w_data_reg & wr_mask);
  assign div_new = ({{(32-DIV_W){1'b0}}, rate_divisor} & ~wr_mask) | (w_data_reg & wr_mask);
  assign stat_word = {27'h0, rx_busy_reg, tx_busy_reg, perr_reg, ferr_reg, rx_ready_reg};
  assign rd_word = (rd_addr == OFS_CTRL) ? ctrl_word :
                   (rd_addr == OFS_DIV) ? {{(32-DIV_W){1'b0}}, rate_divisor} :
                   (rd_addr == OFS_RXD) ? {24'h0, rx_data_reg} :
                   (rd_addr == OFS_STAT) ? stat_word : 32'h0;
  // Reading received data consumes it together with its error flags
  assign rx_clear = ar_take && (rd_addr == OFS_RXD);
  // A data write while the shifter is busy or disabled is dropped
  assign tx_start = wr_do && wr_hit_txd && w_strb_reg[0] && cfg_reg.tx_en && !tx_busy_reg;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_take && !aw_full_reg && !s_axi_bvalid;
      s_axi_wready <= !w_take && !w_full_reg && !s_axi_bvalid;
      if (aw_take)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cfg_reg <= '0;
      rate_divisor <= DIV_RESET;
    end
    else if (wr_do && wr_hit_ctrl)
    begin
      cfg_reg.tx_en <= ctrl_new[CTRL_TX_EN];
      cfg_reg.rx_en <= ctrl_new[CTRL_RX_EN];
      cfg_reg.parity_en <= ctrl_new[CTRL_PAR];
      cfg_reg.stop_two <= ctrl_new[CTRL_STOP2];
      cfg_reg.source_sel <= ctrl_new[CTRL_SRC_LO +: 2];
      cfg_reg.fine_adjust <= ctrl_new[CTRL_FA_LO +: 3];
    end
    else if (wr_do && wr_hit_div)
      rate_divisor <= div_new[DIV_W-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !ar_take && !s_axi_rvalid;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Sub-bit clock
  // ------------------------------------------------------------
  logic sub_bit_tick;

  ubt_rate_gen #(
    .DIV_W(DIV_W)
  ) u_rate (
    .clock(clock),
    .srst(srst),
    .source_sel(cfg_reg.source_sel),
    .rate_divisor(rate_divisor),
    .sub_bit_tick(sub_bit_tick)
  );

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  logic [3:0] tx_pos_reg;
  logic [4:0] tx_rt_reg;
  logic [7:0] tx_data_reg;
  logic [3:0] tx_pos_next;
  logic [3:0] tx_last;
  logic tx_bit_next;

  assign tx_pos_next = tx_pos_reg + 4'h1;
  assign tx_last = POS_PARITY + {3'h0, cfg_reg.parity_en} + {3'h0, cfg_reg.stop_two};
  // Data LSB first, then even parity, then stop level
  assign tx_bit_next = (tx_pos_next <= POS_DATA_LAST) ?
                       tx_data_reg[3'(tx_pos_next - 4'h1)] :
                       (tx_pos_next == POS_PARITY && cfg_reg.parity_en) ?
                       ^tx_data_reg : 1'b1;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      tx_busy_reg <= 1'b0;
      tx_pos_reg <= POS_START;
      tx_rt_reg <= RT_END;
      tx_data_reg <= 8'h0;
      serial_transmit_output <= 1'b1;
    end
    else if (tx_start)
    begin
      tx_busy_reg <= 1'b1;
      tx_pos_reg <= POS_START;
      tx_rt_reg <= ubt_bit_top(cfg_reg.fine_adjust, 1'b0);
      tx_data_reg <= w_data_reg[7:0];
      serial_transmit_output <= 1'b0;
    end
    else if (tx_busy_reg && sub_bit_tick)
    begin
      if (tx_rt_reg != RT_END)
        tx_rt_reg <= tx_rt_reg - 5'h1;
      else if (tx_pos_reg == tx_last)
      begin
        tx_busy_reg <= 1'b0;
        serial_transmit_output <= 1'b1;
      end
      else
      begin
        tx_pos_reg <= tx_pos_next;
        tx_rt_reg <= ubt_bit_top(cfg_reg.fine_adjust, tx_pos_next[0]);
        serial_transmit_output <= tx_bit_next;
      end
    end
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  logic rx_prev_reg;
  logic [3:0] rx_pos_reg;
  logic [4:0] rx_rt_reg;
  logic [2:0] vote_reg;
  logic [7:0] rx_shift_reg;
  logic rx_ferr_reg;
  logic rx_perr_reg;
  logic rx_fall;
  logic in_window;
  logic bit_end;
  logic vote;
  logic [3:0] rx_pos_next;
  logic [3:0] rx_last;
  logic is_stop;
  logic is_parity;
  logic deliver;

  assign rx_fall = rx_prev_reg && !serial_receive_input;
  assign in_window = (rx_rt_reg <= RT_SAMPLE_HI) && (rx_rt_reg >= RT_SAMPLE_LO);
  assign bit_end = rx_busy_reg && sub_bit_tick && (rx_rt_reg == RT_END);
  assign vote = (vote_reg[0] & vote_reg[1]) | (vote_reg[0] & vote_reg[2]) |
                (vote_reg[1] & vote_reg[2]);
  assign rx_pos_next = rx_pos_reg + 4'h1;
  assign rx_last = POS_PARITY + {3'h0, cfg_reg.parity_en} + {3'h0, cfg_reg.stop_two};
  assign is_parity = cfg_reg.parity_en && (rx_pos_reg == POS_PARITY);
  assign is_stop = (rx_pos_reg > POS_DATA_LAST) && !is_parity;
  assign deliver = bit_end && (rx_pos_reg == rx_last);

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rx_prev_reg <= 1'b1;
      rx_busy_reg <= 1'b0;
      rx_pos_reg <= POS_START;
      rx_rt_reg <= RT_END;
      vote_reg <= 3'h0;
      rx_shift_reg <= 8'h0;
      rx_ferr_reg <= 1'b0;
      rx_perr_reg <= 1'b0;
    end
    else
    begin
      rx_prev_reg <= serial_receive_input;
      if (!rx_busy_reg)
      begin
        if (cfg_reg.rx_en && rx_fall)
        begin
          rx_busy_reg <= 1'b1;
          rx_pos_reg <= POS_START;
          rx_rt_reg <= ubt_bit_top(cfg_reg.fine_adjust, 1'b0);
          rx_ferr_reg <= 1'b0;
          rx_perr_reg <= 1'b0;
        end
      end
      else if (sub_bit_tick)
      begin
        if (in_window)
          vote_reg <= {vote_reg[1:0], serial_receive_input};
        if (rx_rt_reg != RT_END)
          rx_rt_reg <= rx_rt_reg - 5'h1;
        else if ((rx_pos_reg == POS_START && vote) || rx_pos_reg == rx_last)
          rx_busy_reg <= 1'b0;
        else
        begin
          rx_pos_reg <= rx_pos_next;
          rx_rt_reg <= ubt_bit_top(cfg_reg.fine_adjust, rx_pos_next[0]);
        end
        if (bit_end && rx_pos_reg != POS_START && rx_pos_reg <= POS_DATA_LAST)
          rx_shift_reg <= {vote, rx_shift_reg[7:1]};
        if (bit_end && is_parity)
          rx_perr_reg <= vote ^ (^rx_shift_reg);
        if (bit_end && is_stop && !vote)
          rx_ferr_reg <= 1'b1;
      end
    end
  end

  // Flags set by a completed frame win over a clearing read in the same cycle
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rx_data_reg <= 8'h0;
      rx_ready_reg <= 1'b0;
      ferr_reg <= 1'b0;
      perr_reg <= 1'b0;
      frame_error_req <= 1'b0;
    end
    else
    begin
      frame_error_req <= deliver && (rx_ferr_reg || (is_stop && !vote));
      if (deliver)
      begin
        rx_data_reg <= rx_shift_reg;
        rx_ready_reg <= 1'b1;
        ferr_reg <= rx_ferr_reg || (is_stop && !vote);
        perr_reg <= rx_perr_reg;
      end
      else if (rx_clear)
      begin
        rx_ready_reg <= 1'b0;
        ferr_reg <= 1'b0;
        perr_reg <= 1'b0;
      end
    end
  end
endmodule

// *** bench/ubt_top_properties.sv ***
// Port-level temporal checks for the serial bit-timing block
`timescale 1ns/1ps
module ubt_top_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial side
  input wire logic serial_transmit_output,
  input wire logic frame_error_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // Low time of the transmit line; even a partial first tick leaves 13 full cycles
  logic [7:0] low_reg;
  logic [7:0] low_next;
  assign low_next = serial_transmit_output ? 8'h00 : low_reg + {7'h00, low_reg != 8'hff};
  always_ff @(posedge clock) low_reg <= srst ? 8'h00 : low_next;
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // The joined address and data are acted on one edge after the take
  a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_ferr_pulse: assert property (frame_error_req |=> !frame_error_req)
    else $error("framing request longer than one cycle");
  a_low_run_min: assert property ($rose(serial_transmit_output) |-> low_reg >= 8'h0d)
    else $error("transmit low run too short");
endmodule

// *** bench/ubt_serial_peer.sv ***
// Remote serial peer: frame sender and transmit-line run recorder
`timescale 1ns/1ps
module ubt_serial_peer (
  // Clock
  input wire logic clock,
  // Serial lines
  input wire logic line_in,
  output logic line_out
);
  int runs[$];
  int run_len = 0;
  logic last_in = 1'b1;
  initial line_out = 1'b1;
  // Each level change closes a run, so alternating data gives one run per bit
  always @(posedge clock)
  begin
    if (line_in !== last_in)
    begin
      runs.push_back(run_len);
      run_len = 0;
    end
    run_len++;
    last_in = line_in;
  end
  function automatic int bit_ticks(input logic [2:0] c, input int p);
    case (c)
      3'h1: return (p % 2) ? 17 : 16;
      3'h2: return 15;
      3'h3: return (p % 2) ? 16 : 15;
      3'h4: return 17;
      default: return 16;
    endcase
  endfunction
  task automatic send(input logic [7:0] d, input logic [2:0] c, input logic stop_val);
    logic [9:0] f;
    f = {stop_val, d, 1'b0};
    for (int p = 0; p < 10; p++)
    begin
      line_out <= f[p];
      repeat (bit_ticks(c, p)) @(posedge clock);
    end
    line_out <= 1'b1;
  endtask
  // Short low pulse that votes high at the start-bit samples
  task automatic glitch();
    line_out <= 1'b0;
    repeat (3) @(posedge clock);
    line_out <= 1'b1;
  endtask
  // Frame of sixteen-clock bits with even parity and two stops; flip sends bad parity
  task automatic send_par(input logic [7:0] d, input logic flip);
    logic [11:0] f;
    f = {2'b11, (^d) ^ flip, d, 1'b0};
    for (int p = 0; p < 12; p++)
    begin
      line_out <= f[p];
      repeat (16) @(posedge clock);
    end
    line_out <= 1'b1;
  endtask
endmodule

// *** bench/test_uart_bit_timing_and_rx_sampler.sv ***
// Self-checking bench for the serial bit-timing block
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("[ERR] %0t got %h exp %h", $time, got, exp); \
    end \
  end
module test_uart_bit_timing_and_rx_sampler;
  import ubt_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, rdv;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, txo, rxi, ferr_req;
  logic [1:0] bresp, rresp, resp;
  int error_cnt = 0, n_tests = 0, fe_seen = 0;
  always #20 clock = ~clock;
  always @(posedge clock) if (ferr_req === 1'b1) fe_seen++;
  ubt_top #(.DIV_W(8)) i_dut (.clock(clock), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_receive_input(rxi), .serial_transmit_output(txo), .frame_error_req(ferr_req));
  ubt_serial_peer i_peer (.clock(clock), .line_in(txo), .line_out(rxi));
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rdv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Bounded status polls; a miss shows up in the following comparison
  task automatic tx_idle();
    for (int i = 0; i < 1000; i++)
    begin
      rd(OFS_STAT);
      if (rdv[STAT_TX_BUSY] === 1'b0) break;
    end
  endtask
  task automatic rx_wait();
    for (int i = 0; i < 20; i++)
    begin
      rd(OFS_STAT);
      if (rdv[STAT_RX_RDY] === 1'b1) break;
    end
  endtask
  task automatic t_regs();
    rd(OFS_CTRL);
    `CHK(rdv, 32'h0)
    rd(OFS_DIV);
    `CHK(rdv, 32'h0)
    rd(5'h14);
    `CHK(resp, RESP_SLVERR)
    wr(5'h18, 32'h1);
    `CHK(resp, RESP_SLVERR)
    wr(OFS_DIV, 32'h1a5);
    rd(OFS_DIV);
    `CHK(rdv, 32'ha5)
  endtask
  // Alternating data makes every bit its own run on the line
  task automatic t_tx_codes();
    wr(OFS_DIV, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      wr(OFS_CTRL, (c << CTRL_FA_LO) | 32'h1);
      rd(OFS_CTRL);
      `CHK(rdv, (c << CTRL_FA_LO) | 32'h1)
      i_peer.runs.delete();
      wr(OFS_TXD, 32'h55);
      tx_idle();
      for (int p = 0; p < 9; p++)
        `CHK(i_peer.runs[p + 1], i_peer.bit_ticks(3'(c), p))
    end
  endtask
  task automatic t_div_parity();
    wr(OFS_DIV, 32'h2);
    wr(OFS_CTRL, 32'h1d);
    i_peer.runs.delete();
    wr(OFS_TXD, 32'h55);
    tx_idle();
    for (int p = 2; p < 9; p++)
      `CHK(i_peer.runs[p], 16 * 3 * 2)
    `CHK(i_peer.runs[9], 2 * 16 * 3 * 2)
  endtask
  task automatic t_rx();
    // Peer runs at exactly the configured rate, so the rate error is zero
    wr(OFS_DIV, 32'h0);
    for (int c = 0; c < 5; c++)
    begin
      wr(OFS_CTRL, (c << CTRL_FA_LO) | 32'h2);
      i_peer.send(8'h3c ^ 8'(c), 3'(c), 1'b1);
      rx_wait();
      `CHK(rdv[STAT_FERR], 1'b0)
      rd(OFS_RXD);
      `CHK(rdv, {24'h0, 8'h3c ^ 8'(c)})
    end
  endtask
  task automatic t_abort();
    i_peer.glitch();
    repeat (40) @(posedge clock);
    rd(OFS_STAT);
    `CHK(rdv[STAT_RX_BUSY], 1'b0)
    `CHK(rdv[STAT_RX_RDY], 1'b0)
    i_peer.send(8'h96, FA_17, 1'b1);
    rx_wait();
    rd(OFS_RXD);
    `CHK(rdv, 32'h96)
  endtask
  task automatic t_ferr();
    fe_seen = 0;
    i_peer.send(8'h81, FA_17, 1'b0);
    rx_wait();
    `CHK(fe_seen, 1)
    `CHK(rdv[STAT_FERR], 1'b1)
    rd(OFS_RXD);
    rd(OFS_STAT);
    `CHK(rdv[STAT_FERR], 1'b0)
  endtask
  // Parity and two-stop reception, good parity then bad parity
  task automatic t_rx_parity();
    wr(OFS_CTRL, 32'he);
    for (int k = 0; k < 2; k++)
    begin
      i_peer.send_par(8'h5b, 1'(k));
      rx_wait();
      `CHK(rdv[STAT_PERR], 1'(k))
      `CHK(rdv[STAT_FERR], 1'b0)
      rd(OFS_RXD);
      `CHK(rdv, 32'h5b)
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    t_regs();
    t_tx_codes();
    t_div_parity();
    t_rx();
    t_abort();
    t_ferr();
    t_rx_parity();
    results();
  end
  // Whole run needs well under 20000 cycles
  initial
  begin
    #(40 * 40000);
    error_cnt++;
    results();
  end
endmodule
bind ubt_top ubt_top_checker i_chk (.clock(clock), .srst(srst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .serial_transmit_output(serial_transmit_output), .frame_error_req(frame_error_req));
